// ==== dv/test_usart_transmit_path_control.sv ====
// self-checking bench of the transmit path control, registers reached over AHB-Lite
// assumes the remote model decodes the wire; bit period is the reset rate of 13 cycles
`timescale 1ns/10ps
`default_nettype none
`include "usx_consts.svh"

module test_usart_transmit_path_control;
    localparam int BIT = 13;
    logic        hclk, hresetn, hsel, hwrite, hready, hresp, global_irq_en, txc_irq_ack;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, csz;
    logic        udre_irq_req, txc_irq_req, tx_o, tx_oe, serial_rx_pin, rx_pin_owned;
    logic        rx_serial_in, rx_bit_tick, ext_clk, line, rx_par, rx_stop, clk_run, par_en;
    logic [3:0]  nbits;
    logic [8:0]  rx_data, d;
    logic [31:0] v;
    int          frame_cnt, base, ticks;
    int          error_cnt  = 0;
    int          num_checks = 0;
    integer      seed       = 32'hAE7A17AA;

    assign line = tx_oe ? tx_o : 1'b1;

    usx_tx_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .global_irq_en(global_irq_en),
        .txc_irq_ack(txc_irq_ack), .udre_irq_req(udre_irq_req), .txc_irq_req(txc_irq_req),
        .serial_tx_pin_o(tx_o), .serial_tx_pin_oe(tx_oe), .serial_rx_pin(serial_rx_pin),
        .ext_transfer_clk_pin(ext_clk), .rx_pin_owned(rx_pin_owned),
        .rx_serial_in(rx_serial_in), .rx_bit_tick(rx_bit_tick));

    usx_remote_model #(.BIT(BIT)) u_remote (.hclk(hclk), .line(line), .nbits(nbits),
        .par_en(par_en), .clk_run(clk_run), .rx_data(rx_data), .rx_par(rx_par),
        .rx_stop(rx_stop), .frame_cnt(frame_cnt), .ext_clk(ext_clk));

    function automatic logic [3:0] nb(input logic [2:0] c);
        if (c < 3'h4) return 4'h5 + {1'b0, c};
        return (c == 3'h7) ? 4'h9 : 4'h8;
    endfunction

    function automatic logic pb(input logic [8:0] x, input logic [3:0] n, input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) p = p ^ x[i];
        end
        return p;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= `USX_HTRANS_NSEQ;
        hwrite <= wr;
        hsize  <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic wait_frames(input int n);
        int t;
        t = 0;
        while (frame_cnt < n && t < 6000) begin
            @(posedge hclk);
            t++;
        end
        chk("frame count", n, frame_cnt);
        @(negedge hclk);
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    initial begin
        repeat (40000) @(posedge hclk);
        error_cnt++;
        $display("watchdog ran out");
        stop_test();
    end

    initial begin
        {hresetn, hsel, hwrite, global_irq_en, txc_irq_ack, clk_run, par_en} = 7'h00;
        {haddr, hwdata, htrans, hsize} = 69'h0;
        serial_rx_pin = 1'b1;
        nbits         = 4'h8;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk("status after reset", `USX_OFF_STAT, 32'h1);
        chk("pin owned after reset", 32'h0, {31'h0, tx_oe});
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            csz = (k == 4 || k == 6) ? 3'h7 : ((k == 5) ? 3'h5 : 3'(k % 4));
            v   = $random(seed);
            d   = v[8:0];
            if (k == 4) d[8] = 1'b1;
            if (k == 6) d[8] = 1'b0;
            nbits  <= nb(csz);
            par_en <= v[9];
            bus(1'b1, `USX_OFF_CTRLC, {25'h0, 1'b0, v[11], v[9], v[10], csz});
            bus(1'b1, `USX_OFF_CTRLB, {30'h0, 1'b1, d[8]});
            bus(1'b1, `USX_OFF_DATA, {23'h0, d});
            wait_frames(k + 1);
            chk("frame data", {23'h0, d & ((9'h1 << nb(csz)) - 9'h1)}, {23'h0, rx_data});
            if (v[9]) chk("parity", {31'h0, pb(d, nb(csz), v[10])}, {31'h0, rx_par});
            chk("stop bit", 32'h1, {31'h0, rx_stop});
            chk("pin owned", 32'h1, {31'h0, tx_oe});
            repeat (3 * BIT) @(posedge hclk);
            rdchk("status after frame", `USX_OFF_STAT, 32'h3);
            bus(1'b1, `USX_OFF_STAT, 32'h2);
            rdchk("status after clear", `USX_OFF_STAT, 32'h1);
        end
        $display("test frames done");
        nbits  <= 4'h8;
        par_en <= 1'b0;
        global_irq_en <= 1'b1;
        bus(1'b1, `USX_OFF_CTRLC, 32'h3);
        bus(1'b1, `USX_OFF_CTRLB, 32'h1A);
        // the enable lands on the edge the task returns at, so look half a cycle later
        @(negedge hclk);
        chk("empty request", 32'h1, {31'h0, udre_irq_req});
        base = frame_cnt;
        bus(1'b1, `USX_OFF_DATA, 32'h5A);
        bus(1'b1, `USX_OFF_DATA, 32'hC3);
        rdchk("status buffer full", `USX_OFF_STAT, 32'h4);
        chk("empty request held off", 32'h0, {31'h0, udre_irq_req});
        wait_frames(base + 2);
        chk("second frame", 32'hC3, {23'h0, rx_data});
        repeat (3 * BIT) @(posedge hclk);
        @(negedge hclk);
        chk("complete request", 32'h1, {31'h0, txc_irq_req});
        @(posedge hclk);
        global_irq_en <= 1'b0;
        @(negedge hclk);
        chk("complete request masked", 32'h0, {31'h0, txc_irq_req});
        chk("empty request masked", 32'h0, {31'h0, udre_irq_req});
        @(posedge hclk);
        global_irq_en <= 1'b1;
        txc_irq_ack   <= 1'b1;
        @(posedge hclk);
        txc_irq_ack <= 1'b0;
        @(negedge hclk);
        chk("complete after service", 32'h0, {31'h0, txc_irq_req});
        bus(1'b1, `USX_OFF_CTRLB, 32'h2);
        @(negedge hclk);
        chk("empty request disabled", 32'h0, {31'h0, udre_irq_req});
        $display("test requests done");
        base = frame_cnt;
        bus(1'b1, `USX_OFF_DATA, 32'h55);
        bus(1'b1, `USX_OFF_DATA, 32'hA3);
        bus(1'b1, `USX_OFF_CTRLB, 32'h0);
        // one more edge so the controller has really entered its drain state
        repeat (2) @(negedge hclk);
        chk("pin kept while draining", 32'h1, {31'h0, tx_oe});
        wait_frames(base + 2);
        chk("drained frame", 32'hA3, {23'h0, rx_data});
        repeat (3 * BIT) @(posedge hclk);
        @(negedge hclk);
        chk("pin released", 32'h0, {31'h0, tx_oe});
        $display("test disable done");
        bus(1'b1, `USX_OFF_CTRLB, 32'h4);
        for (int k = 0; k < 6; k++) begin
            @(posedge hclk);
            v = $random(seed);
            serial_rx_pin <= v[0];
            @(negedge hclk);
            chk("receive input", {31'h0, serial_rx_pin}, {31'h0, rx_serial_in});
        end
        chk("receive pin owned", 32'h1, {31'h0, rx_pin_owned});
        bus(1'b1, `USX_OFF_CTRLC, 32'h43);
        @(posedge hclk);
        clk_run <= 1'b1;
        ticks = 0;
        for (int k = 0; k < 88; k++) begin
            @(posedge hclk);
            if (rx_bit_tick === 1'b1) ticks++;
            if (k == 79) clk_run <= 1'b0;
        end
        chk("external clock ticks", 32'd10, ticks);
        bus(1'b1, `USX_OFF_CTRLB, 32'h0);
        @(negedge hclk);
        chk("receive input released", 32'h1, {31'h0, rx_serial_in});
        $display("test receive done");
        stop_test();
    end
endmodule

`default_nettype wire

// ==== dv/usx_remote_model.sv ====
// remote serial device: decodes frames on the transmit wire and makes an external clock
// assumes the wire reads high (pull-up) whenever the transmitter does not own the pin
`timescale 1ns/10ps
`default_nettype none

module usx_remote_model #(
    parameter int BIT = 13
) (
    // clock
    input  wire logic       hclk,
    // wire, expected format and clock run enable
    input  wire logic       line,
    input  wire logic [3:0] nbits,
    input  wire logic       par_en,
    input  wire logic       clk_run,
    // decoded frame and external clock
    output logic [8:0]      rx_data,
    output logic            rx_par,
    output logic            rx_stop,
    output int              frame_cnt,
    output logic            ext_clk
);
    logic [1:0] div_q = 2'h0;
    logic       ck_q  = 1'b0;
    logic [8:0] d;

    assign ext_clk = ck_q;

    // the clock stands still low outside the windows in which the bench lets it run
    always @(posedge hclk) begin
        if (!clk_run) begin
            div_q <= 2'h0;
            ck_q  <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) begin
                ck_q <= ~ck_q;
            end
        end
    end

    initial begin
        rx_data   = 9'h000;
        rx_par    = 1'b0;
        rx_stop   = 1'b1;
        frame_cnt = 0;
        forever begin
            @(posedge hclk);
            if (line === 1'b0) begin
                repeat (BIT / 2) @(posedge hclk);
                d = 9'h000;
                for (int i = 0; i < 9; i++) begin
                    if (4'(i) < nbits) begin
                        repeat (BIT) @(posedge hclk);
                        d[i] = line;
                    end
                end
                if (par_en) begin
                    repeat (BIT) @(posedge hclk);
                    rx_par = line;
                end
                repeat (BIT) @(posedge hclk);
                rx_stop   = line;
                rx_data   = d;
                frame_cnt = frame_cnt + 1;
            end
        end
    end
endmodule

`default_nettype wire

// ==== rtl/usx_consts.svh ====
// register offsets, field positions, reset values and widths of the serial transmit block
// assumes a 32-bit AHB-Lite slave decoding the low address byte
`ifndef USX_CONSTS_SVH
`define USX_CONSTS_SVH

`define USX_OFF_DATA     8'h00
`define USX_OFF_STAT     8'h04
`define USX_OFF_CTRLB    8'h08
`define USX_OFF_CTRLC    8'h0C
`define USX_OFF_BAUD     8'h10

`define USX_STAT_UDRE    0
`define USX_STAT_TXC     1
`define USX_STAT_BUSY    2

`define USX_CB_NINTH     0
`define USX_CB_TX_ENABLE_BIT      1
`define USX_CB_RXEN      2
`define USX_CB_UDRIE     3
`define USX_CB_TXCIE     4

`define USX_CC_PAR_ODD   3
`define USX_CC_PAR_EN    4
`define USX_CC_STOP2     5
`define USX_CC_SYNC      6

`define USX_CSZ_NINE     3'h7
`define USX_CTRLB_RST    5'h00
`define USX_CTRLC_RST    7'h03
`define USX_BAUD_RST     12'h00C
`define USX_FRAME_IDLE   13'h1FFF
`define USX_HTRANS_NSEQ  2'h2

`endif

// ==== rtl/usx_pkg.sv ====
// types and shared functions of the serial transmit block
// assumes usx_consts.svh is on the include path
`include "usx_consts.svh"

package usx_pkg;

    typedef enum logic [1:0] {
        USX_TX_OFF   = 2'b00,
        USX_TX_ON    = 2'b01,
        USX_TX_DRAIN = 2'b10
    } usx_tx_state_t;

    // data bits per character for a size code
    function automatic logic [3:0] usx_nbits(input logic [2:0] csz);
        case (csz)
            3'h0:          usx_nbits = 4'h5;
            3'h1:          usx_nbits = 4'h6;
            3'h2:          usx_nbits = 4'h7;
            `USX_CSZ_NINE: usx_nbits = 4'h9;
            default:       usx_nbits = 4'h8;
        endcase
    endfunction

    // even parity over the first n bits, inverted for odd
    function automatic logic usx_parity(input logic [8:0] d, input logic [3:0] n,
                                        input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                p = p ^ d[i];
            end
        end
        usx_parity = p;
    endfunction

endpackage

// ==== rtl/usx_tx_ctrl.sv ====
// serial port transmit path control with AHB-Lite register access
// assumes the system clock hclk, one master, and pins synchronous to hclk
`timescale 1ns/10ps
`default_nettype none
`include "usx_consts.svh"

module usx_tx_ctrl
    import usx_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // interrupt requests towards the core
    input  wire logic        global_irq_en,
    input  wire logic        txc_irq_ack,
    output logic             udre_irq_req,
    output logic             txc_irq_req,
    // transmit pin takeover
    output logic             serial_tx_pin_o,
    output logic             serial_tx_pin_oe,
    // receive pin takeover and receiver clocking
    input  wire logic        serial_rx_pin,
    input  wire logic        ext_transfer_clk_pin,
    output logic             rx_pin_owned,
    output logic             rx_serial_in,
    output logic             rx_bit_tick
);

    // bus phase registers
    logic        wr_q;
    logic [7:0]  waddr_q;
    logic [31:0] rdata_q;

    // software registers
    logic [4:0]  ctrlb_q;
    logic [6:0]  ctrlc_q;
    logic [11:0] baud_q;

    // transmit buffer and flags
    logic        buf_full_q;
    logic [8:0]  buf_data_q;
    logic        txc_q;
    usx_tx_state_t tx_st_q;

    // clocking
    logic [11:0] div_q;
    logic        xck_q;
    logic        tick;
    logic        int_tick;
    logic        xck_rise;

    // shifter links
    logic        sh_busy;
    logic        sh_last;
    logic        sh_bit;
    logic        load;
    logic [12:0] frame_w;
    logic [3:0]  len_w;
    logic [3:0]  nbits_w;

    // decoded bus strobes and derived status
    logic        addr_ok;
    logic        wr_data;
    logic        wr_stat;
    logic        tx_on;
    logic        udre;

    assign addr_ok = hsel && hready && (htrans == `USX_HTRANS_NSEQ);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q    <= 1'b0;
            waddr_q <= 8'h00;
        end else begin
            wr_q    <= addr_ok && hwrite;
            waddr_q <= haddr[7:0];
        end
    end

    assign wr_data = wr_q && (waddr_q == `USX_OFF_DATA);
    assign wr_stat = wr_q && (waddr_q == `USX_OFF_STAT);

    // read data captured in the address phase; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                `USX_OFF_DATA:  rdata_q <= {23'h0, buf_data_q};
                `USX_OFF_STAT:  rdata_q <= {29'h0, sh_busy, txc_q, udre};
                `USX_OFF_CTRLB: rdata_q <= {27'h0, ctrlb_q};
                `USX_OFF_CTRLC: rdata_q <= {25'h0, ctrlc_q};
                `USX_OFF_BAUD:  rdata_q <= {20'h0, baud_q};
                default:        rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrlb_q <= `USX_CTRLB_RST;
            ctrlc_q <= `USX_CTRLC_RST;
            baud_q  <= `USX_BAUD_RST;
        end else if (wr_q) begin
            if (waddr_q == `USX_OFF_CTRLB) begin
                ctrlb_q <= hwdata[4:0];
            end
            if (waddr_q == `USX_OFF_CTRLC) begin
                ctrlc_q <= hwdata[6:0];
            end
            if (waddr_q == `USX_OFF_BAUD) begin
                baud_q <= hwdata[11:0];
            end
        end
    end

    // transmit buffer; the ninth bit is sampled with the low byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buf_data_q <= 9'h000;
        end else if (wr_data) begin
            buf_data_q <= {ctrlb_q[`USX_CB_NINTH], hwdata[7:0]};
        end
    end

    // a write landing on the transfer cycle refills the buffer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buf_full_q <= 1'b0;
        end else if (wr_data) begin
            buf_full_q <= 1'b1;
        end else if (load) begin
            buf_full_q <= 1'b0;
        end
    end

    // the empty flag has no storage of its own, so writes to it do nothing
    assign udre = !buf_full_q;

    // set wins over both clears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txc_q <= 1'b0;
        end else if (sh_last && !buf_full_q) begin
            txc_q <= 1'b1;
        end else if (txc_irq_ack || (wr_stat && hwdata[`USX_STAT_TXC])) begin
            txc_q <= 1'b0;
        end
    end

    assign udre_irq_req = udre && ctrlb_q[`USX_CB_UDRIE] && global_irq_en;
    assign txc_irq_req  = txc_q && ctrlb_q[`USX_CB_TXCIE] && global_irq_en;

    // transmitter enable with deferred switch-off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_st_q <= USX_TX_OFF;
        end else begin
            case (tx_st_q)
                USX_TX_OFF: begin
                    if (ctrlb_q[`USX_CB_TX_ENABLE_BIT]) begin
                        tx_st_q <= USX_TX_ON;
                    end
                end
                USX_TX_ON: begin
                    if (!ctrlb_q[`USX_CB_TX_ENABLE_BIT]) begin
                        tx_st_q <= USX_TX_DRAIN;
                    end
                end
                USX_TX_DRAIN: begin
                    if (ctrlb_q[`USX_CB_TX_ENABLE_BIT]) begin
                        tx_st_q <= USX_TX_ON;
                    end else if (!buf_full_q && !sh_busy) begin
                        tx_st_q <= USX_TX_OFF;
                    end
                end
                default: tx_st_q <= USX_TX_OFF;
            endcase
        end
    end

    assign tx_on = (tx_st_q != USX_TX_OFF);
    assign serial_tx_pin_oe = tx_on;
    assign serial_tx_pin_o  = tx_on ? sh_bit : 1'b1;

    // bit clock: internal divider or the sampled external clock
    assign xck_rise = ext_transfer_clk_pin && !xck_q;
    assign int_tick = (div_q == baud_q);
    assign tick = ctrlc_q[`USX_CC_SYNC] ? xck_rise : int_tick;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xck_q <= 1'b0;
        end else begin
            xck_q <= ext_transfer_clk_pin;
        end
    end

    // restarted on an idle load so the start bit gets a full period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 12'h000;
        end else if (int_tick || (load && !sh_busy)) begin
            div_q <= 12'h000;
        end else begin
            div_q <= div_q + 12'h001;
        end
    end

    // receiver pin and clock hand-off
    assign rx_pin_owned = ctrlb_q[`USX_CB_RXEN];
    assign rx_serial_in = ctrlb_q[`USX_CB_RXEN] ? serial_rx_pin : 1'b1;
    assign rx_bit_tick  = tick;

    // frame assembly
    assign nbits_w = usx_nbits(ctrlc_q[2:0]);

    always_comb begin
        frame_w = `USX_FRAME_IDLE;
        frame_w[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < nbits_w) begin
                frame_w[i + 1] = buf_data_q[i];
            end
        end
        if (ctrlc_q[`USX_CC_PAR_EN]) begin
            frame_w[nbits_w + 4'h1] = usx_parity(buf_data_q, nbits_w,
                                                 ctrlc_q[`USX_CC_PAR_ODD]);
        end
        len_w = nbits_w + 4'h2 + {3'h0, ctrlc_q[`USX_CC_PAR_EN]}
              + {3'h0, ctrlc_q[`USX_CC_STOP2]};
    end

    assign load = buf_full_q && tx_on && (!sh_busy || sh_last);

    usx_tx_shift u_shift (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (tick),
        .load    (load),
        .frame   (frame_w),
        .len     (len_w),
        .tx_bit  (sh_bit),
        .busy    (sh_busy),
        .last    (sh_last)
    );

    // checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_write_data;
        wr_data ##1 1'b1;
    endsequence

    property p_udre_clear;
        s_write_data |-> !udre && (buf_data_q[7:0] == $past(hwdata[7:0]));
    endproperty
    a_udre_clear: assert property (p_udre_clear)
        else $error("data write did not clear buffer-empty");

    property p_udre_set;
        load && !wr_data |=> udre;
    endproperty
    a_udre_set: assert property (p_udre_set)
        else $error("buffer-empty not set after transfer");

    property p_udre_irq;
        udre && ctrlb_q[`USX_CB_UDRIE] && global_irq_en |-> udre_irq_req;
    endproperty
    a_udre_irq: assert property (p_udre_irq)
        else $error("buffer-empty request missing");

    property p_txc_set;
        sh_last && !buf_full_q |=> txc_q ##0 (txc_irq_req == (ctrlb_q[`USX_CB_TXCIE]
                                               && global_irq_en));
    endproperty
    a_txc_set: assert property (p_txc_set)
        else $error("transmit-complete not set at frame end");

    property p_txc_clr;
        txc_q && txc_irq_ack && !sh_last |=> !txc_q;
    endproperty
    a_txc_clr: assert property (p_txc_clr)
        else $error("transmit-complete not cleared by service");

    property p_drain_hold;
        tx_st_q == USX_TX_DRAIN && sh_busy |=> serial_tx_pin_oe;
    endproperty
    a_drain_hold: assert property (p_drain_hold)
        else $error("transmitter released while shifting");

    property p_start_bit;
        load |=> (serial_tx_pin_o == 1'b0) && serial_tx_pin_oe;
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("no start bit after load");

    property p_parity;
        ctrlc_q[`USX_CC_PAR_EN] |-> frame_w[nbits_w + 4'h1] ==
            ((^(buf_data_q & ~(9'h1FF << nbits_w))) ^ ctrlc_q[`USX_CC_PAR_ODD]);
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity bit wrong");

    property p_release;
        !tx_on |-> !serial_tx_pin_oe && serial_tx_pin_o;
    endproperty
    a_release: assert property (p_release)
        else $error("transmit pin still driven when off");

    property p_rx_pin;
        rx_pin_owned |-> rx_serial_in == serial_rx_pin;
    endproperty
    a_rx_pin: assert property (p_rx_pin)
        else $error("receive pin not taken over");

endmodule
`default_nettype wire

// ==== rtl/usx_tx_shift.sv ====
// transmit shift register: sends a prepared frame lsb first, one bit per tick
// assumes the controller builds the frame and loads only when idle or on the last tick
`timescale 1ns/10ps
`default_nettype none
`include "usx_consts.svh"

module usx_tx_shift
    import usx_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // control
    input  wire logic        tick,
    input  wire logic        load,
    input  wire logic [12:0] frame,
    input  wire logic [3:0]  len,
    // line and status
    output logic             tx_bit,
    output logic             busy,
    output logic             last
);

    logic [12:0] sh_q;
    logic [3:0]  cnt_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_q  <= `USX_FRAME_IDLE;
            cnt_q <= 4'h0;
        end else if (load) begin
            sh_q  <= frame;
            cnt_q <= len;
        end else if (tick && (cnt_q != 4'h0)) begin
            // ones shift in behind, so the line idles high
            sh_q  <= {1'b1, sh_q[12:1]};
            cnt_q <= cnt_q - 4'h1;
        end
    end

    assign tx_bit = sh_q[0];
    assign busy   = (cnt_q != 4'h0);
    assign last   = tick && (cnt_q == 4'h1);

endmodule
`default_nettype wire
